// ===== core/adsl_map.svh
// Register selects, field positions, reset values and counts of the converter serial link.
// Included by the link module; definitions only.
`ifndef ADSL_MAP_SVH
`define ADSL_MAP_SVH

// Register select codes carried in the communications byte
`define ADSL_SEL_COMM      3'h0
`define ADSL_SEL_SETUP     3'h1
`define ADSL_SEL_CLOCK     3'h2
`define ADSL_SEL_DATA      3'h3
`define ADSL_SEL_TEST      3'h4
`define ADSL_SEL_NOOP      3'h5
`define ADSL_SEL_OFFSET    3'h6
`define ADSL_SEL_GAIN      3'h7

// Communications byte fields
`define ADSL_COMM_READY    7
`define ADSL_COMM_SEL_HI   6
`define ADSL_COMM_SEL_LO   4
`define ADSL_COMM_READ     3
`define ADSL_COMM_STBY     2
`define ADSL_COMM_CH_HI    1
`define ADSL_COMM_CH_LO    0

// Setup byte fields: mode select, non-zero starts a calibration
`define ADSL_SETUP_MD_HI   7
`define ADSL_SETUP_MD_LO   6

// Transfer lengths in serial clocks
`define ADSL_LEN_BYTE      5'h08
`define ADSL_LEN_WORD      5'h10
`define ADSL_LEN_WIDE      5'h18

// Consecutive ones on the serial input that reset the interface
`define ADSL_ONES_RESET    6'h20

// Reset values
`define ADSL_RST_PINS      3'h6
`define ADSL_RST_SETUP     8'h00
`define ADSL_RST_CLOCK     8'h00
`define ADSL_RST_OFFSET    24'h000000
`define ADSL_RST_GAIN      24'h000000

`endif

// ===== core/adsl_pkg.sv
// Types shared by the converter serial link.
// Constants live in adsl_map.svh.
package adsl_pkg;

    typedef enum logic [1:0] {
        ADSL_COMM,
        ADSL_WRITE,
        ADSL_READ
    } adsl_mode_t;

    typedef struct packed {
        logic [7:0]  clock_reg;
        logic [7:0]  setup_reg;
        logic [23:0] offset_reg;
        logic [23:0] gain_reg;
        logic [1:0]  channel;
        logic        standby;
    } adsl_cfg_t;

    typedef struct packed {
        adsl_mode_t  mode;
        logic [2:0]  target;
        logic [4:0]  bit_cnt;
        logic [5:0]  ones_cnt;
        logic [23:0] shift;
        logic        sclk_prev;
        logic        dout;
        logic        dout_oe;
        logic        ready_n;
        logic        cal_start;
        adsl_cfg_t   cfg;
    } adsl_state_t;

endpackage

// ===== core/adsl_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs are quasi-static relative to clk; the first stage is read only by the second.
`timescale 1ns/1ps
module adsl_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // Reset value is a level from the parent; reset is synchronous so this is a plain clocked load
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= reset_val;
            sync_out <= reset_val;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ===== core/adsl_link.sv
// Device end of the converter's half-duplex serial register link.
// Assumes a host master with serial clock idling high, pins asynchronous to clk,
// and new_result/result_data from conversion logic on clk.
// Functional notes
// - Output line idle during write transfers.
// - Input line ignored during read transfers.
// - Converter shifts read bits MSB first.
// - Ready flag readable in communications register.
// - Setup 0x40 applies settings, starts self-calibration.
// - Command 0x38 reads 16-bit data, two bytes.
// - Every access starts with communications write.
// - Ready low on result, high after data read.
// - 32 input ones reset interface, keep registers.
`timescale 1ns/1ps
`include "adsl_map.svh"
module adsl_link
    import adsl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe,
    output logic             result_ready_n,
    input  wire logic        new_result,
    input  wire logic [15:0] result_data,
    output adsl_cfg_t        cfg,
    output logic             cal_start
);
    adsl_state_t state_reg;
    adsl_state_t state_next;
    logic [2:0]  pins_s;
    logic        sclk_s;
    logic        cs_s_n;
    logic        din_s;
    logic        sclk_rise;
    logic        sclk_fall;

    // Clock and select reset to their idle high levels so no false edge follows reset
    adsl_sync #(.WIDTH(3)) u_sync (
        .clk       (clk),
        .rst_n     (rst_n),
        .async_in  ({sclk, cs_n, din}),
        .reset_val (`ADSL_RST_PINS),
        .sync_out  (pins_s)
    );

    assign sclk_s = pins_s[2];
    assign cs_s_n = pins_s[1];
    assign din_s  = pins_s[0];

    // Edges are seen on the synchronised clock, so the serial clock must stay well below clk/4
    assign sclk_rise = sclk_s & ~state_reg.sclk_prev;
    assign sclk_fall = ~sclk_s & state_reg.sclk_prev;

    // Register length fixes how many clocks a transfer takes
    function automatic logic [4:0] xfer_len(input logic [2:0] sel);
        case (sel)
            `ADSL_SEL_DATA:   xfer_len = `ADSL_LEN_WORD;
            `ADSL_SEL_OFFSET: xfer_len = `ADSL_LEN_WIDE;
            `ADSL_SEL_GAIN:   xfer_len = `ADSL_LEN_WIDE;
            default:          xfer_len = `ADSL_LEN_BYTE;
        endcase
    endfunction

    always_comb begin
        logic [7:0]  cbyte;
        logic [23:0] wval;
        logic [4:0]  cnt_inc;
        cbyte      = {state_reg.shift[6:0], din_s};
        wval       = {state_reg.shift[22:0], din_s};
        cnt_inc    = state_reg.bit_cnt + 5'h01;
        state_next = state_reg;
        // Calibration start lasts one cycle unless a setup write raises it
        state_next.cal_start = 1'b0;
        state_next.sclk_prev = sclk_s;
        // Edges while deselected are ignored and lose no state
        if (!cs_s_n) begin
            if (sclk_rise && state_reg.mode != ADSL_READ) begin
                // Ones on the input are counted only while the input is listened to
                if (!din_s) begin
                    state_next.ones_cnt = 6'h00;
                end else if (state_reg.ones_cnt != `ADSL_ONES_RESET) begin
                    state_next.ones_cnt = state_reg.ones_cnt + 6'h01;
                end
                if (din_s && state_next.ones_cnt == `ADSL_ONES_RESET) begin
                    state_next.mode    = ADSL_COMM;
                    state_next.bit_cnt = 5'h00;
                end else begin
                    // Wide registers take all 24 bits; byte registers keep the low byte
                    state_next.shift   = wval;
                    state_next.bit_cnt = cnt_inc;
                    if (state_reg.mode == ADSL_COMM && cnt_inc == `ADSL_LEN_BYTE) begin
                        state_next.bit_cnt = 5'h00;
                        // A byte with its top bit set is not a command and is dropped
                        if (!cbyte[`ADSL_COMM_READY]) begin
                            state_next.target      = cbyte[`ADSL_COMM_SEL_HI:`ADSL_COMM_SEL_LO];
                            state_next.cfg.channel = cbyte[`ADSL_COMM_CH_HI:`ADSL_COMM_CH_LO];
                            state_next.cfg.standby = cbyte[`ADSL_COMM_STBY];
                            if (cbyte[`ADSL_COMM_READ]) begin
                                state_next.mode = ADSL_READ;
                                case (cbyte[`ADSL_COMM_SEL_HI:`ADSL_COMM_SEL_LO])
                                    `ADSL_SEL_COMM: begin
                                        state_next.shift = {state_reg.ready_n, cbyte[6:0], 16'h0000};
                                    end
                                    `ADSL_SEL_SETUP: begin
                                        state_next.shift = {state_reg.cfg.setup_reg, 16'h0000};
                                    end
                                    `ADSL_SEL_CLOCK: begin
                                        state_next.shift = {state_reg.cfg.clock_reg, 16'h0000};
                                    end
                                    `ADSL_SEL_DATA: begin
                                        // Result captured here; a newer one waits for the next read
                                        state_next.shift = {result_data, 8'h00};
                                    end
                                    `ADSL_SEL_OFFSET: begin
                                        state_next.shift = state_reg.cfg.offset_reg;
                                    end
                                    `ADSL_SEL_GAIN: begin
                                        state_next.shift = state_reg.cfg.gain_reg;
                                    end
                                    default: begin
                                        state_next.shift = 24'h000000;
                                    end
                                endcase
                            end else if (cbyte[`ADSL_COMM_SEL_HI:`ADSL_COMM_SEL_LO]
                                         != `ADSL_SEL_COMM) begin
                                state_next.mode = ADSL_WRITE;
                            end
                        end
                    end else if (state_reg.mode == ADSL_WRITE
                                 && cnt_inc == xfer_len(state_reg.target)) begin
                        state_next.mode    = ADSL_COMM;
                        state_next.bit_cnt = 5'h00;
                        case (state_reg.target)
                            `ADSL_SEL_SETUP: begin
                                state_next.cfg.setup_reg = wval[7:0];
                                state_next.cal_start =
                                    |wval[`ADSL_SETUP_MD_HI:`ADSL_SETUP_MD_LO];
                            end
                            `ADSL_SEL_CLOCK: begin
                                state_next.cfg.clock_reg = wval[7:0];
                            end
                            `ADSL_SEL_OFFSET: begin
                                state_next.cfg.offset_reg = wval;
                            end
                            `ADSL_SEL_GAIN: begin
                                state_next.cfg.gain_reg = wval;
                            end
                            default: begin
                                // Data, test and no-op writes are dropped
                            end
                        endcase
                    end
                end
            end else if (state_reg.mode == ADSL_READ) begin
                // Input bits are not looked at here
                // Change after the fall so the bit is settled at the host's rising edge
                if (sclk_fall) begin
                    state_next.dout  = state_reg.shift[23];
                    state_next.shift = {state_reg.shift[22:0], 1'b0};
                end else if (sclk_rise) begin
                    state_next.bit_cnt = cnt_inc;
                    if (cnt_inc == xfer_len(state_reg.target)) begin
                        state_next.mode     = ADSL_COMM;
                        state_next.bit_cnt  = 5'h00;
                        state_next.ones_cnt = 6'h00;
                        if (state_reg.target == `ADSL_SEL_DATA) begin
                            state_next.ready_n = 1'b1;
                        end
                    end
                end
            end
        end
        // Output is driven only during a read with the part selected
        state_next.dout_oe = (state_next.mode == ADSL_READ) && !cs_s_n;
        // Low while released so a shared line rests at its pull-up
        if (!state_next.dout_oe) begin
            state_next.dout = 1'b0;
        end
        // A new result in the cycle a read completes keeps the flag low
        if (new_result) begin
            state_next.ready_n = 1'b0;
        end
    end

    // Reset is synchronous, so these are plain clocked loads
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg                <= '0;
            state_reg.mode           <= ADSL_COMM;
            state_reg.sclk_prev      <= 1'b1;
            state_reg.ready_n        <= 1'b1;
            state_reg.cfg.setup_reg  <= `ADSL_RST_SETUP;
            state_reg.cfg.clock_reg  <= `ADSL_RST_CLOCK;
            state_reg.cfg.offset_reg <= `ADSL_RST_OFFSET;
            state_reg.cfg.gain_reg   <= `ADSL_RST_GAIN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Every output is a register field; no logic sits after the flops
    assign dout           = state_reg.dout;
    assign dout_oe        = state_reg.dout_oe;
    assign result_ready_n = state_reg.ready_n;
    assign cfg            = state_reg.cfg;
    assign cal_start      = state_reg.cal_start;
endmodule

// ===== verification/adsl_link_properties.sv
// Concurrent checks on the ports of adsl_link.
// Assumes the pins reach the core through two-stage synchronisers.
`timescale 1ns/1ps
module adsl_link_properties
    import adsl_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        din,
    input wire logic        dout,
    input wire logic        dout_oe,
    input wire logic        result_ready_n,
    input wire logic        new_result,
    input wire logic [15:0] result_data,
    input wire adsl_cfg_t   cfg,
    input wire logic        cal_start
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_dout_quiet_off: assert property (!dout_oe |-> !dout)
        else $error("dout driven while output disabled");
    a_read_ignores_din: assert property (dout_oe && $past(dout_oe) |-> $stable(cfg))
        else $error("config changed during a read");
    a_ready_on_result: assert property (new_result |=> !result_ready_n)
        else $error("ready not low after a new result");
    a_ready_clears_read: assert property ($rose(result_ready_n) |->
        !dout_oe && ($past(dout_oe) || $past(dout_oe, 2)))
        else $error("ready rose without a finished read");
    a_cal_one_pulse: assert property (cal_start |=> !cal_start)
        else $error("calibration start longer than one cycle");
    a_cal_needs_mode: assert property (cal_start |->
        ##[0:1] (cfg.setup_reg[7:6] != 2'h0))
        else $error("calibration start without mode bits");
    a_oe_needs_cs: assert property (cs_n [*4] |-> !dout_oe)
        else $error("output enabled while deselected");
    a_idle_keeps_cfg: assert property (cs_n [*8] |-> $stable(cfg))
        else $error("config changed while deselected");
    a_dout_after_fall: assert property (sclk [*8] |-> $stable(dout))
        else $error("dout moved while serial clock high");
    cover property ($rose(cal_start));
    cover property ($rose(dout_oe));
    cover property ($rose(result_ready_n));
    cover property ($fell(result_ready_n));
endmodule
bind adsl_link adsl_link_properties props (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .dout_oe(dout_oe), .result_ready_n(result_ready_n),
    .new_result(new_result), .result_data(result_data), .cfg(cfg), .cal_start(cal_start));

// ===== verification/adsl_host_model.sv
// Host serial master, mode 3, MSB first, selecting the part through two frame sync lines.
// Assumes a pull-up on the data line; its clock is unrelated to the core clock.
`timescale 1ns/1ps
module adsl_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_oe,
    input  wire logic framed
);
    logic receive_frame_sync;
    logic transmit_frame_sync;

    // Either active-low sync alone selects the part
    assign cs_n = receive_frame_sync & transmit_frame_sync;
    initial begin
        sclk                = 1'b1;
        receive_frame_sync  = 1'b1;
        transmit_frame_sync = 1'b1;
        din                 = 1'b1;
    end
    // One frame of n bits; din still toggles in reads to prove it is ignored.
    // A plain port selects on the transmit line, a framed one on receive sync.
    task automatic shift(input int n, input logic [23:0] wd, output logic [23:0] rd);
        real half;
        // Framed frames run at 2.5 MHz, under the framed limit; plain ones at 8 MHz
        half = framed ? 200.0 : 62.5;
        rd = 24'h000000;
        if (framed) begin
            receive_frame_sync = 1'b0;
        end else begin
            transmit_frame_sync = 1'b0;
        end
        #100;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b0;
            din  = wd[i];
            #(half);
            sclk = 1'b1;
            rd = {rd[22:0], dout_oe ? dout : 1'b1};
            #(half);
        end
        #100;
        receive_frame_sync  = 1'b1;
        transmit_frame_sync = 1'b1;
        din                 = 1'b1;
        // Gap keeps the select high between frames
        #100;
    endtask
endmodule

// ===== verification/adsl_link_test.sv
// Self-checking bench for adsl_link with a host master model.
// Assumes the conversion side is played by the bench through new_result.
`timescale 1ns/1ps
module adsl_link_test;
    import adsl_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        sclk;
    logic        cs_n;
    logic        din;
    logic        dout;
    logic        dout_oe;
    logic        result_ready_n;
    logic        new_result;
    logic [15:0] result_data;
    adsl_cfg_t   cfg;
    logic        cal_start;
    logic        framed;
    logic [7:0]  n_cal;
    logic [23:0] r;
    int          n_mismatch;
    int          checks;
    int          cycles;

    adsl_link dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe), .result_ready_n(result_ready_n), .new_result(new_result),
        .result_data(result_data), .cfg(cfg), .cal_start(cal_start));
    adsl_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
        .framed(framed));

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic give(input logic [15:0] v);
        @(posedge clk);
        result_data <= v;
        new_result <= 1'b1;
        @(posedge clk);
        new_result <= 1'b0;
        repeat (2) @(posedge clk);
        chk(result_ready_n, 1'b0);
    endtask
    task automatic t_config();
        host.shift(16, 24'h00200c, r);
        host.shift(16, 24'h001040, r);
        repeat (8) @(posedge clk);
        chk(cfg.clock_reg, 8'h0c);
        chk(cfg.setup_reg, 8'h40);
        chk(cfg.channel, 2'h0);
        chk(n_cal, 8'h01);
    endtask
    task automatic t_read(input logic [15:0] v);
        give(v);
        host.shift(8, 24'h000038, r);
        host.shift(16, {8'h00, ~v}, r);
        repeat (8) @(posedge clk);
        chk(r[15:0], v);
        chk(result_ready_n, 1'b1);
        chk(cfg.setup_reg, 8'h40);
    endtask
    task automatic t_status();
        host.shift(16, 24'h000800, r);
        chk(r[7:0], 8'h88);
        give(16'h1234);
        host.shift(16, 24'h000800, r);
        chk(r[7:0], 8'h08);
    endtask
    task automatic t_wide();
        host.shift(8, 24'h000060, r);
        host.shift(24, 24'h123456, r);
        host.shift(8, 24'h000070, r);
        host.shift(24, 24'hedcba9, r);
        host.shift(8, 24'h000068, r);
        host.shift(24, 24'h000000, r);
        chk(r, 24'h123456);
        host.shift(8, 24'h000078, r);
        host.shift(24, 24'h000000, r);
        chk(r, 24'hedcba9);
        chk(cfg.offset_reg, 24'h123456);
        chk(cfg.gain_reg, 24'hedcba9);
        host.shift(8, 24'h000005, r);
        repeat (8) @(posedge clk);
        chk({cfg.standby, cfg.channel}, 3'h5);
    endtask
    task automatic t_framed();
        @(posedge clk);
        framed <= 1'b1;
        t_read(16'h3c5a);
        @(posedge clk);
        framed <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_ones();
        // Setup takes five ones, then 27 more complete the run of 32
        host.shift(8, 24'h000010, r);
        host.shift(8, 24'h00001f, r);
        host.shift(24, 24'hffffff, r);
        host.shift(3, 24'h000007, r);
        host.shift(16, 24'h002005, r);
        repeat (8) @(posedge clk);
        chk(cfg.clock_reg, 8'h05);
        chk(cfg.setup_reg, 8'h1f);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cal_start === 1'b1) begin
            n_cal <= n_cal + 8'h01;
        end
    end
    // Whole run is about 7,400 cycles; the ceiling of 20000 leaves ample margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        rst_n = 1'b0;
        new_result = 1'b0;
        framed = 1'b0;
        result_data = 16'h0000;
        n_cal = 8'h00;
        n_mismatch = 0;
        checks = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_config();
        t_read(16'ha5c3);
        t_read(16'h8001);
        t_status();
        t_read(16'h7ffe);
        t_wide();
        t_framed();
        t_ones();
        complete_run();
    end
endmodule
